/* slo_pkg.sv */
// shared constants and types for the stn panel output stage
package slo_pkg;

    // clock rate
    localparam int CLK_MHZ = 50;

    // line clock high time, least time in ns, rounded up to cycles
    localparam int LINE_PULSE_NS  = 40;
    localparam int LINE_PULSE_CYC = ((LINE_PULSE_NS * CLK_MHZ) + 999) / 1000 < 1 ? 1 :
                                    ((LINE_PULSE_NS * CLK_MHZ) + 999) / 1000;

    // gap between power sequencing steps, in us, and in cycles
    localparam int SEQ_STEP_US  = 1000;
    localparam int SEQ_STEP_CYC = SEQ_STEP_US * CLK_MHZ;

    // shift clock phases per data unit: setup, strobe high, strobe low
    localparam logic [1:0] SCK_PH_IDLE = 2'h0;
    localparam logic [1:0] SCK_PH_HIGH = 2'h1;
    localparam logic [1:0] SCK_PH_LOW  = 2'h2;

    // data bus value at reset and while data is off
    localparam logic [7:0] DATA_IDLE = 8'h00;

    // reset value of the ac modulation output
    localparam logic AC_MOD_RESET = 1'b0;

    // panel data bus organisation
    typedef enum logic [1:0] {
        SLO_MODE_4SINGLE = 2'h0,
        SLO_MODE_DUAL    = 2'h1,
        SLO_MODE_8SINGLE = 2'h2
    } slo_mode_t;

    // power sequencer states
    typedef enum logic [2:0] {
        SLO_PWR_OFF        = 3'h0,
        SLO_PWR_LOGIC      = 3'h1,
        SLO_PWR_DATA       = 3'h2,
        SLO_PWR_FULL       = 3'h3,
        SLO_PWR_DOWN_DATA  = 3'h4,
        SLO_PWR_DOWN_LOGIC = 3'h5
    } slo_pwr_state_t;

endpackage : slo_pkg

/* slo_pwr_if.sv */
// carrier between the output stage and its power sequencer
`timescale 1ns/10ps
`default_nettype none
interface slo_pwr_if;
    logic req_on;       // panel power wanted
    logic logic_en;     // logic supply enable
    logic data_en;      // pixel data allowed onto the pins
    logic contrast_en;  // contrast supply enable
    logic busy;         // sequence step in progress

    modport ctrl (output req_on, input logic_en, data_en, contrast_en, busy);
    modport seq  (input req_on, output logic_en, data_en, contrast_en, busy);
endinterface : slo_pwr_if
`default_nettype wire

/* slo_power_seq.sv */
// power sequencer: logic supply, then data, then contrast, and back
`timescale 1ns/10ps
`default_nettype none
module slo_power_seq
    import slo_pkg::*;
#(
    parameter int STEP_CYC = slo_pkg::SEQ_STEP_CYC
) (
    // clock and reset
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    // link to the output stage
    slo_pwr_if.seq    pwr
);
    import slo_pkg::*;

    localparam int CW = $clog2(STEP_CYC + 1);
    localparam logic [CW-1:0] STEP_LOAD = CW'(STEP_CYC - 1);

    slo_pwr_state_t  state;
    logic [CW-1:0]   timer;
    logic            step_done;

    assign step_done = (timer == '0);

    // step timer, reloaded on every state change
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer <= '0;
        end else if (state == SLO_PWR_OFF && pwr.req_on) begin
            timer <= STEP_LOAD;
        end else if (state == SLO_PWR_FULL && !pwr.req_on) begin
            timer <= STEP_LOAD;
        end else if (step_done && state != SLO_PWR_OFF && state != SLO_PWR_FULL) begin
            timer <= STEP_LOAD;
        end else if (!step_done) begin
            timer <= timer - CW'(1);
        end
    end

    // sequence: each step waits a full gap so supplies settle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state           <= SLO_PWR_OFF;
            pwr.logic_en    <= 1'b0;
            pwr.data_en     <= 1'b0;
            pwr.contrast_en <= 1'b0;
        end else begin
            case (state)
                SLO_PWR_OFF: if (pwr.req_on) begin
                    pwr.logic_en <= 1'b1;
                    state        <= SLO_PWR_LOGIC;
                end
                SLO_PWR_LOGIC: if (step_done) begin
                    if (pwr.req_on) begin
                        pwr.data_en <= 1'b1;
                        state       <= SLO_PWR_DATA;
                    end else begin
                        state <= SLO_PWR_DOWN_LOGIC;
                    end
                end
                SLO_PWR_DATA: if (step_done) begin
                    if (pwr.req_on) begin
                        pwr.contrast_en <= 1'b1;
                        state           <= SLO_PWR_FULL;
                    end else begin
                        state <= SLO_PWR_DOWN_DATA;
                    end
                end
                SLO_PWR_FULL: if (!pwr.req_on) begin
                    pwr.contrast_en <= 1'b0;
                    state           <= SLO_PWR_DOWN_DATA;
                end
                SLO_PWR_DOWN_DATA: if (step_done) begin
                    pwr.data_en <= 1'b0;
                    state       <= SLO_PWR_DOWN_LOGIC;
                end
                SLO_PWR_DOWN_LOGIC: if (step_done) begin
                    pwr.logic_en <= 1'b0;
                    state        <= SLO_PWR_OFF;
                end
                default: begin
                    state <= SLO_PWR_OFF;
                end
            endcase
        end
    end

    // steady only in off or full power
    assign pwr.busy = (state != SLO_PWR_OFF) && (state != SLO_PWR_FULL);

endmodule : slo_power_seq
`default_nettype wire

/* slo_panel_out.sv */
// passive-matrix stn panel output stage
// Operation
// - pulse line clock at each line start
// - 4-bit single scan uses low nibble only
// - dual scan: top low nibble, bottom high
// - 8-bit single scan uses all eight lines
// - one shift strobe per nibble or byte
// - toggle ac modulation to reverse drive polarity
// - output enabling panel logic supply
// - separate output enabling contrast supply
// - order supplies and data at power changes
// - frame start marks first scan line data
`timescale 1ns/10ps
`default_nettype none
module slo_panel_out
    import slo_pkg::*;
#(
    parameter int SEQ_CYC = slo_pkg::SEQ_STEP_CYC  // cycles between power steps
) (
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    // configuration
    input  wire slo_pkg::slo_mode_t mode_i,
    input  wire logic              panel_on_i,
    // pixel stream from the fetch logic
    input  wire logic              pix_valid_i,
    input  wire logic [7:0]        pix_data_i,
    output var  logic              pix_ready_o,
    // line and frame events from the timing logic
    input  wire logic              line_start_i,
    input  wire logic              frame_start_i,
    // panel pins
    output var  logic [7:0]        panel_pixel_data_o,
    output var  logic              shift_clock_o,
    output var  logic              line_clock_out_o,
    output var  logic              frame_start_out_o,
    output var  logic              ac_mod_o,
    output var  logic              panel_logic_supply_en_o,
    output var  logic              panel_contrast_supply_en_o,
    // status
    output var  logic              panel_ready_o
);
    import slo_pkg::*;

    localparam int LW = $clog2(LINE_PULSE_CYC + 1);
    localparam logic [LW-1:0] LINE_LOAD = LW'(LINE_PULSE_CYC);

    // pin timing, counted in clock edges from the edge that takes a unit:
    //   edge 0: valid and ready high, unit taken, ready drops
    //   edge 1: mapped unit on the bus, strobe still low
    //   edge 2: strobe high, panel latches on this rise
    //   edge 3: strobe low, ready back up, next unit may go here
    // so the stream peaks at one unit every three clocks; the bus is
    // steady a full clock either side of the strobe rise, which buys
    // setup and hold at the panel without any fine timing
    //
    // line events, counted from the edge that sees line_start_i:
    //   edge 1: line clock high, frame start high on a first line,
    //           ac modulation flipped on a first line
    //   edge 3: line clock and frame start low again
    // a line event inside a running pulse restarts it

    // place one pixel unit on the bus according to panel organisation
    function automatic logic [7:0] slo_map_data(input slo_mode_t mode,
                                                input logic [7:0] unit);
        logic [7:0] bus;
        bus = DATA_IDLE;
        case (mode)
            SLO_MODE_4SINGLE: bus = {4'h0, unit[3:0]};
            SLO_MODE_DUAL:    bus = {unit[7:4], unit[3:0]};
            SLO_MODE_8SINGLE: bus = unit;
            default:          bus = unit;
        endcase
        return bus;
    endfunction : slo_map_data

    slo_pwr_if pwr ();

    logic [1:0]    sck_phase;
    logic [LW-1:0] line_cnt;
    logic          accept;
    logic          line_go;

    // power sequencer owns all supply and data-enable ordering
    slo_power_seq #(
        .STEP_CYC (SEQ_CYC)
    ) u_power_seq (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .pwr      (pwr.seq)
    );

    assign pwr.req_on = panel_on_i;

    // supply enables, copied from the sequencer flops
    // the copy costs one clock of lag but keeps every pin on its own flop,
    // so no decode glitch can ever reach a supply switch
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            panel_logic_supply_en_o    <= 1'b0;
            panel_contrast_supply_en_o <= 1'b0;
            panel_ready_o              <= 1'b0;
        end else begin
            panel_logic_supply_en_o    <= pwr.logic_en;
            panel_contrast_supply_en_o <= pwr.contrast_en;
            panel_ready_o              <= pwr.data_en && !pwr.busy;
        end
    end

    // a unit is taken only in the idle phase and with data allowed the clock before
    // ready comes from a flop, so no path runs from valid back to ready
    assign accept  = pix_valid_i && pix_ready_o;
    // line events are dropped while data is off, so pins stay quiet
    assign line_go = line_start_i && pwr.data_en;

    // ready is registered; it falls the cycle after a unit is taken
    // limitation: ready is formed from the data enable of the cycle before,
    // so a unit offered in the very clock that data is switched off is
    // swallowed; the fetch side should stop offering once power is dropped
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pix_ready_o <= 1'b0;
        end else begin
            pix_ready_o <= pwr.data_en && (sck_phase == SCK_PH_LOW ||
                           (sck_phase == SCK_PH_IDLE && !accept));
        end
    end

    // shift strobe: data set up, strobe high, strobe low, then next unit
    // the strobe is built from flops, not gated from the clock, so it
    // cannot glitch; the cost is three clocks per unit
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_phase     <= SCK_PH_IDLE;
            shift_clock_o <= 1'b0;
        end else if (!pwr.data_en) begin
            sck_phase     <= SCK_PH_IDLE;
            shift_clock_o <= 1'b0;
        end else begin
            case (sck_phase)
                SCK_PH_IDLE: if (accept) begin
                    sck_phase <= SCK_PH_HIGH;
                end
                SCK_PH_HIGH: begin
                    shift_clock_o <= 1'b1;
                    sck_phase     <= SCK_PH_LOW;
                end
                SCK_PH_LOW: begin
                    shift_clock_o <= 1'b0;
                    sck_phase     <= SCK_PH_IDLE;
                end
                default: begin
                    shift_clock_o <= 1'b0;
                    sck_phase     <= SCK_PH_IDLE;
                end
            endcase
        end
    end

    // data bus: held through the strobe, forced low while data is off
    // in nibble mode the high lane is written with zeros, so unused lines
    // stay quiet rather than keeping stale data
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            panel_pixel_data_o <= DATA_IDLE;
        end else if (!pwr.data_en) begin
            panel_pixel_data_o <= DATA_IDLE;
        end else if (accept) begin
            panel_pixel_data_o <= slo_map_data(mode_i, pix_data_i);
        end
    end

    // line clock pulse of fixed width at each line start
    // the pulse is cut as soon as data goes off, so the panel never sees
    // a line clock while its data lines are held low
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_cnt         <= '0;
            line_clock_out_o <= 1'b0;
        end else if (!pwr.data_en) begin
            line_cnt         <= '0;
            line_clock_out_o <= 1'b0;
        end else if (line_go) begin
            line_cnt         <= LINE_LOAD - LW'(1);
            line_clock_out_o <= 1'b1;
        end else if (line_cnt != '0) begin
            line_cnt <= line_cnt - LW'(1);
        end else begin
            line_clock_out_o <= 1'b0;
        end
    end

    // frame start rides on the first line pulse of the frame
    // a frame flag without a line event is ignored; alone it means nothing
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_start_out_o <= 1'b0;
        end else if (!pwr.data_en) begin
            frame_start_out_o <= 1'b0;
        end else if (line_go) begin
            frame_start_out_o <= frame_start_i;
        end else if (line_cnt == '0) begin
            frame_start_out_o <= 1'b0;
        end
    end

    // ac modulation flips once per frame; held low while data is off
    // so the panel never sees a stuck level with supplies coming up
    // flipping on the first line gives whole frames of each polarity,
    // which keeps the average drive across the cells at zero
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ac_mod_o <= AC_MOD_RESET;
        end else if (!pwr.data_en) begin
            ac_mod_o <= AC_MOD_RESET;
        end else if (line_go && frame_start_i) begin
            ac_mod_o <= !ac_mod_o;
        end
    end

endmodule : slo_panel_out
`default_nettype wire

/* slo_panel_out_asserts.sv */
// assertion checker for the stn panel output stage
`timescale 1ns/10ps
`default_nettype none
module slo_panel_out_asserts
    import slo_pkg::*;
#(
    parameter int SEQ_CYC = 8
) (
    // clock and reset
    input wire logic               clock_i,
    input wire logic               rst_n_i,
    // stream and events
    input wire slo_pkg::slo_mode_t mode_i,
    input wire logic               pix_valid_i,
    input wire logic [7:0]         pix_data_i,
    input wire logic               pix_ready_o,
    input wire logic               line_start_i,
    input wire logic               frame_start_i,
    // panel pins and status
    input wire logic [7:0]         panel_pixel_data_o,
    input wire logic               shift_clock_o,
    input wire logic               line_clock_out_o,
    input wire logic               frame_start_out_o,
    input wire logic               ac_mod_o,
    input wire logic               panel_logic_supply_en_o,
    input wire logic               panel_contrast_supply_en_o,
    input wire logic               panel_ready_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // a line event only counts once the panel is fully up
    logic take;
    logic ev;
    assign take = pix_valid_i && pix_ready_o;
    assign ev   = line_start_i && panel_ready_o;

    // clocks the logic supply pin has been high, held at its ceiling
    int logic_on_cnt;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            logic_on_cnt <= 0;
        end else if (!panel_logic_supply_en_o) begin
            logic_on_cnt <= 0;
        end else if (logic_on_cnt < 2 * SEQ_CYC) begin
            logic_on_cnt <= logic_on_cnt + 1;
        end
    end

    AST_LINE_PULSE: assert property (ev |=> line_clock_out_o [*2])
        else $error("line clock pulse too short");
    AST_FRAME_PULSE: assert property (ev && frame_start_i |=> frame_start_out_o)
        else $error("frame start missing");
    AST_FRAME_IN_LINE: assert property (frame_start_out_o |-> line_clock_out_o)
        else $error("frame start outside line pulse");
    AST_AC_FLIP: assert property (ev && frame_start_i |=> ac_mod_o != $past(ac_mod_o))
        else $error("ac modulation did not toggle");
    AST_AC_HOLD: assert property (ev && !frame_start_i |=> $stable(ac_mod_o))
        else $error("ac modulation moved mid frame");
    AST_STROBE: assert property (take |=> !shift_clock_o ##1 shift_clock_o ##1 !shift_clock_o)
        else $error("shift strobe misplaced");
    AST_MAP_LOW: assert property (take && mode_i == SLO_MODE_4SINGLE
        |=> panel_pixel_data_o == ($past(pix_data_i) & 8'h0f))
        else $error("nibble bus mapping wrong");
    AST_MAP_FULL: assert property (take && mode_i != SLO_MODE_4SINGLE
        |=> panel_pixel_data_o == $past(pix_data_i))
        else $error("full bus mapping wrong");
    AST_SUPPLY_ORDER: assert property (panel_contrast_supply_en_o |-> panel_logic_supply_en_o)
        else $error("contrast on without logic supply");
    AST_DATA_POWERED: assert property (shift_clock_o |-> panel_logic_supply_en_o)
        else $error("data strobed without logic supply");
    AST_CONTRAST_LATE: assert property (
        $rose(panel_contrast_supply_en_o) |-> logic_on_cnt >= 2 * SEQ_CYC)
        else $error("contrast on before the data step ended");

    // main scenarios reached
    cover property (ev && frame_start_i);
    cover property (take ##2 shift_clock_o);
    cover property ($fell(panel_contrast_supply_en_o));
endmodule : slo_panel_out_asserts

bind slo_panel_out slo_panel_out_asserts #(.SEQ_CYC(SEQ_CYC)) u_chk (.clock_i, .rst_n_i,
    .mode_i, .pix_valid_i, .pix_data_i, .pix_ready_o, .line_start_i, .frame_start_i,
    .panel_pixel_data_o, .shift_clock_o, .line_clock_out_o, .frame_start_out_o, .ac_mod_o,
    .panel_logic_supply_en_o, .panel_contrast_supply_en_o, .panel_ready_o);
`default_nettype wire

/* slo_panel_model.sv */
// behavioural stn panel: latches units and watches supply order
`timescale 1ns/10ps
`default_nettype none
module slo_panel_model (
    // clock
    input  wire logic        clock_i,
    // panel pins
    input  wire logic [7:0]  pixel_data_i,
    input  wire logic        shift_clock_i,
    input  wire logic        logic_supply_i,
    input  wire logic        contrast_supply_i,
    // observations
    output var  logic [7:0]  last_unit_o,
    output var  logic [15:0] unit_count_o,
    output var  logic        fault_o
);
    logic sck_q = 1'b0;
    initial begin
        last_unit_o = 8'h00;
        unit_count_o = 16'h0000;
        fault_o = 1'b0;
    end
    // sampled on the system clock so the strobe edge never races data
    always @(posedge clock_i) begin
        sck_q <= shift_clock_i;
        if (shift_clock_i && !sck_q) begin
            last_unit_o <= pixel_data_i;
            unit_count_o <= unit_count_o + 16'h0001;
        end
        // a real panel may latch up here
        if ((shift_clock_i || contrast_supply_i) && !logic_supply_i) begin
            fault_o <= 1'b1;
        end
    end
endmodule : slo_panel_model
`default_nettype wire

/* tb_slo_panel_out.sv */
// self-checking bench for the stn panel output stage
`timescale 1ns/10ps
`default_nettype none
module tb_slo_panel_out;
    import slo_pkg::*;
    localparam int SEQ = 8;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    slo_mode_t mode_i = SLO_MODE_4SINGLE;
    logic panel_on_i = 1'b0, pix_valid_i = 1'b0, line_start_i = 1'b0, frame_start_i = 1'b0;
    logic [7:0] pix_data_i = 8'h00, panel_pixel_data_o, last_unit;
    logic pix_ready_o, shift_clock_o, line_clock_out_o, frame_start_out_o, ac_mod_o;
    logic panel_logic_supply_en_o, panel_contrast_supply_en_o, panel_ready_o, fault;
    logic [15:0] n_units, exp_units = 16'h0000, lfsr = 16'h7d60;
    int errors = 0, cmp_count = 0;

    always #10 clock_i = ~clock_i;

    slo_panel_out #(.SEQ_CYC(SEQ)) u_dut (.clock_i, .rst_n_i, .mode_i, .panel_on_i,
        .pix_valid_i, .pix_data_i, .pix_ready_o, .line_start_i, .frame_start_i,
        .panel_pixel_data_o, .shift_clock_o, .line_clock_out_o, .frame_start_out_o, .ac_mod_o,
        .panel_logic_supply_en_o, .panel_contrast_supply_en_o, .panel_ready_o);
    slo_panel_model u_panel (.clock_i, .pixel_data_i(panel_pixel_data_o),
        .shift_clock_i(shift_clock_o), .logic_supply_i(panel_logic_supply_en_o),
        .contrast_supply_i(panel_contrast_supply_en_o), .last_unit_o(last_unit),
        .unit_count_o(n_units), .fault_o(fault));

    function automatic logic [15:0] lfsr_next(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    // nibble mode keeps the high lines quiet
    function automatic logic [7:0] map_unit(logic [1:0] m, logic [7:0] d);
        return (m == 2'h0) ? {4'h0, d[3:0]} : d;
    endfunction : map_unit

    task automatic check(logic [7:0] seen, logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        if (errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // returns at the falling edge after the unit was taken
    task automatic wait_take();
        int n = 0;
        while (pix_ready_o !== 1'b1 && n < 100) begin
            n++;
            @(negedge clock_i);
        end
        @(negedge clock_i);
        exp_units++;
    endtask : wait_take

    task automatic send(logic [1:0] m, logic [7:0] d);
        mode_i = slo_mode_t'(m);
        pix_data_i = d;
        pix_valid_i = 1'b1;
        wait_take();
        pix_valid_i = 1'b0;
        repeat (3) @(negedge clock_i);
        check(last_unit, map_unit(m, d));
    endtask : send

    task automatic line_evt(logic f, logic on);
        logic a;
        a = ac_mod_o;
        line_start_i = 1'b1;
        frame_start_i = f;
        @(negedge clock_i);
        line_start_i = 1'b0;
        frame_start_i = 1'b0;
        check({line_clock_out_o, frame_start_out_o, ac_mod_o}, {on, on & f, on & (a ^ f)});
        @(negedge clock_i);
        check({line_clock_out_o, frame_start_out_o}, {on, on & f});
        @(negedge clock_i);
        check({line_clock_out_o, frame_start_out_o}, 8'h00);
    endtask : line_evt

    // step panel power, note when each enable reaches the new level
    task automatic power(logic on);
        int tl = -1, tr = -1, tc = -1;
        panel_on_i = on;
        for (int k = 0; k < 4 * SEQ + 10; k++) begin
            @(negedge clock_i);
            if (tl < 0 && panel_logic_supply_en_o === on) tl = k;
            if (tr < 0 && pix_ready_o === on) tr = k;
            if (tc < 0 && panel_contrast_supply_en_o === on) tc = k;
        end
        check(on ? (tl < tr && tr < tc) : (tc < tr && tr < tl), 8'h01);
        check((on ? tc - tl : tl - tc) >= SEQ, 8'h01);
        check({panel_logic_supply_en_o, panel_contrast_supply_en_o}, {on, on});
        check(panel_ready_o, on);
    endtask : power

    initial begin
        repeat (12) @(negedge clock_i);
        rst_n_i = 1'b1;
        @(negedge clock_i);
        line_evt(1'b1, 1'b0);
        power(1'b1);
        for (int m = 0; m < 4; m++) send(m[1:0], 8'ha5);
        send(2'h1, 8'hff);
        send(2'h0, 8'hf0);
        line_evt(1'b1, 1'b1);
        line_evt(1'b0, 1'b1);
        // random mix of units and line events
        for (int i = 0; i < 40; i++) begin
            lfsr = lfsr_next(lfsr);
            if (lfsr[0]) line_evt(lfsr[1], 1'b1);
            else send(lfsr[3:2], lfsr[15:8]);
        end
        // back-to-back burst with valid held high
        pix_valid_i = 1'b1;
        for (int i = 0; i < 6; i++) begin
            pix_data_i = lfsr[7:0];
            lfsr = lfsr_next(lfsr);
            wait_take();
        end
        pix_valid_i = 1'b0;
        repeat (4) @(negedge clock_i);
        check(n_units[7:0], exp_units[7:0]);
        power(1'b0);
        line_evt(1'b1, 1'b0);
        check(fault, 8'h00);
        give_verdict();
    end

    // whole run is well under 2000 cycles
    initial begin
        #200000;
        errors++;
        give_verdict();
    end
endmodule : tb_slo_panel_out
`default_nettype wire
